// ### rtl/apr_core.sv
// converter strobe sequencer: power mode, conversion timing, byte readout
// assumes host pins are asynchronous and a sampled 14-bit code arrives on i_sample
`timescale 1ns/1ps
module apr_core
	import apr_pkg::*;
#(
	parameter int CONV_CYC = CONV_CYCLES, // conversion length in cycles
	parameter bit BIPOLAR = 1'b1 // 1: offset binary coding, 0: straight binary
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_conv_strobe_n, // convert strobe pin, active low
	input wire logic i_read_conv, // read/convert select pin
	input wire logic i_high_byte_select, // byte select pin
	input wire logic [RESULT_W-1:0] i_sample, // raw converter code, straight binary
	output logic o_conv_done_n, // end of conversion, active low
	output logic [BYTE_W-1:0] o_result_outputs, // data bus value
	output logic [BYTE_W-1:0] o_result_outputs_oe, // high while driving bus
	output logic [1:0] o_ref_power, // reference power state
	output logic o_track // high while tracking the input
);

	// three-stage synchronisers; stage 1 only feeds stage 2
	// the pins carry no clock of their own, so every level is treated as asynchronous
	// cost: an edge is seen about four system clocks after the pin moves
	apr_host_s sync1, sync2, sync3, host; // host holds the agreed level
	// synchroniser chain, resets to idle levels
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sync1 <= 3'b100;
			sync2 <= 3'b100;
			sync3 <= 3'b100;
		end else begin
			sync1 <= {i_conv_strobe_n, i_read_conv, i_high_byte_select};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// a change counts only once stages two and three agree
	// each pin is filtered on its own, so a select may settle a cycle apart from the strobe
	// the host keeps select steady around the strobe edge, which hides that skew
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			host <= 3'b100;
		end else begin
			if (sync2.conv_strobe_n == sync3.conv_strobe_n)
				host.conv_strobe_n <= sync3.conv_strobe_n;
			if (sync2.read_conv == sync3.read_conv)
				host.read_conv <= sync3.read_conv;
			if (sync2.high_byte_select == sync3.high_byte_select)
				host.high_byte_select <= sync3.high_byte_select;
		end
	end

	// falling strobe edge, with select taken from the same sample
	// previous level resets high, the idle level of the strobe pin, so no false edge follows reset
	logic strobe_prev; // last agreed strobe level
	logic fall; // one-cycle falling-edge pulse
	logic rise; // one-cycle rising-edge pulse
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			strobe_prev <= 1'b1;
		else
			strobe_prev <= host.conv_strobe_n;
	end
	assign fall = strobe_prev & ~host.conv_strobe_n;
	assign rise = ~strobe_prev & host.conv_strobe_n;

	apr_state_e state; // sequencer state
	logic keep_ref; // power-down choice latched at second edge
	logic [15:0] conv_cnt; // conversion cycles left
	logic [RESULT_W-1:0] result; // latched coded result

	// main sequencer; starts in shutdown since power-up waits for a strobe
	// there is no reset pin on the device; the system reset only stands in for power-on
	// edges during conversion are ignored, so a stray strobe cannot cut a conversion short
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state <= APR_OFF;
			keep_ref <= 1'b0;
			conv_cnt <= 16'h0000;
		end else begin
			unique case (state)
				// idle states wait for a strobe edge with select low
				APR_OFF, APR_STANDBY: begin
					if (fall && !host.read_conv)
						state <= APR_ACQ;
				end
				// second edge ends tracking and latches the mode
				APR_ACQ: begin
					if (fall) begin
						keep_ref <= ~host.read_conv;
						conv_cnt <= 16'(CONV_CYC - 1);
						state <= APR_CONV;
					end
				end
				// conversion runs on the free internal clock
				APR_CONV: begin
					if (conv_cnt == 16'h0000)
						state <= APR_DONE;
					else
						conv_cnt <= conv_cnt - 16'h0001;
				end
				// third edge with select high opens the bus
				APR_DONE: begin
					if (fall && host.read_conv)
						state <= APR_READ;
					else if (fall) // a low select restarts acquisition
						state <= APR_ACQ;
				end
				// read ends on strobe high; drop to the chosen power state
				APR_READ: begin
					if (rise)
						state <= keep_ref ? APR_STANDBY : APR_OFF;
				end
				default: state <= APR_OFF;
			endcase
		end
	end

	// result latch at conversion end, with output coding applied
	// offset binary is the straight code with its top bit inverted, so one xor is enough
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			result <= 14'h0000;
		else if (state == APR_CONV && conv_cnt == 16'h0000)
			result <= BIPOLAR ? (i_sample ^ MIDSCALE) : i_sample;
	end

	// done flag: low at end, high again when acquisition restarts
	// the flag stays low through the read, so the host may poll it at any time
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			o_conv_done_n <= 1'b1;
		else if (state == APR_CONV && conv_cnt == 16'h0000)
			o_conv_done_n <= 1'b0;
		else if (fall && (state == APR_OFF || state == APR_STANDBY || state == APR_DONE)
			&& !host.read_conv)
			o_conv_done_n <= 1'b1;
	end

	// bus driver: only in read state, byte picked by select
	// data is forced to zero while released, so a floating bus never shows stale bits
	// the release is taken on the rise itself, in the same cycle that the state leaves read
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_result_outputs <= 8'h00;
			o_result_outputs_oe <= 8'h00;
		end else if (state == APR_READ && !rise) begin
			o_result_outputs_oe <= 8'hff;
			if (host.high_byte_select)
				o_result_outputs <= {2'b00, result[RESULT_W-1:BYTE_W]};
			else
				o_result_outputs <= result[BYTE_W-1:0];
		end else begin
			o_result_outputs <= 8'h00;
			o_result_outputs_oe <= 8'h00;
		end
	end

	// reference power and tracking indicators
	// the reference shows active from acquisition through read; the settle wait is the host's
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_ref_power <= PWR_OFF;
			o_track <= 1'b0;
		end else begin
			o_track <= (state == APR_ACQ);
			unique case (state)
				APR_OFF: o_ref_power <= PWR_OFF;
				APR_STANDBY: o_ref_power <= PWR_STANDBY;
				default: o_ref_power <= PWR_ACTIVE;
			endcase
		end
	end

	// helper: cycles spent converting
	// only the conversion-time assertion reads it
	logic [15:0] conv_age;
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			conv_age <= 16'h0000;
		else if (state == APR_CONV)
			conv_age <= conv_age + 16'h0001;
		else
			conv_age <= 16'h0000;
	end

	AST_MODE_LATCH: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(state == APR_ACQ && fall) |=> (keep_ref == !$past(host.read_conv)))
		else $error("mode not latched from select");
	AST_STANDBY: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(state == APR_READ && rise && keep_ref) |=> state == APR_STANDBY ##1 o_ref_power == PWR_STANDBY)
		else $error("standby not entered");
	AST_SHUTDOWN: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(state == APR_READ && rise && !keep_ref) |=> state == APR_OFF ##1 o_ref_power == PWR_OFF)
		else $error("shutdown not entered");
	AST_WAKE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		((state == APR_OFF || state == APR_STANDBY) && fall && !host.read_conv) |=> state == APR_ACQ)
		else $error("wake edge missed");
	AST_IGNORE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		((state == APR_OFF || state == APR_STANDBY) && fall && host.read_conv) |=> $stable(state))
		else $error("edge with select high acted");
	AST_CONV_TIME: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		conv_age <= 16'(CONV_CYC))
		else $error("conversion overran");
	AST_DONE_FALL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(state == APR_CONV && conv_cnt == 16'h0000) |=> !o_conv_done_n && state == APR_DONE)
		else $error("done flag late");
	AST_FLOAT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(state == APR_ACQ || state == APR_CONV) |=> o_result_outputs_oe == 8'h00)
		else $error("bus driven during conversion");
	AST_RELEASE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(state == APR_READ && rise) |=> o_result_outputs_oe == 8'h00)
		else $error("bus not released");
	AST_HI_ZERO: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_result_outputs_oe != 8'h00 && $past(host.high_byte_select) |-> o_result_outputs[7:6] == 2'b00)
		else $error("high byte top bits set");
	AST_DONE_RISE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		($rose(o_conv_done_n)) |-> state == APR_ACQ)
		else $error("done released outside acquisition");

	// a start edge from either idle state shows tracking two cycles later
	AST_TRACK_ON: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		((state == APR_OFF || state == APR_STANDBY) && fall && !host.read_conv) |=> ##1 o_track)
		else $error("tracking not shown after start");

	// a read edge opens every data line
	AST_READ_OPEN: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(state == APR_DONE && fall && host.read_conv) |=> ##1 o_result_outputs_oe == 8'hff)
		else $error("bus not driven on read");

	// low byte while the select is low
	AST_LOW_BYTE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(state == APR_READ && !rise && !host.high_byte_select) |=> o_result_outputs == result[BYTE_W-1:0])
		else $error("low byte wrong");

	// high byte while the select is high
	AST_HIGH_BYTE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(state == APR_READ && !rise && host.high_byte_select) |=> o_result_outputs[5:0] == result[13:8])
		else $error("high byte wrong");

	// an edge with select low after done starts a new acquisition
	AST_RESTART: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(state == APR_DONE && fall && !host.read_conv) |=> state == APR_ACQ)
		else $error("restart edge missed");

	// no edge leaves conversion early
	AST_CONV_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(state == APR_CONV && conv_cnt != 16'h0000) |=> state == APR_CONV)
		else $error("conversion cut short");

	// coding: only the top bit may differ from the raw code, and only when bipolar
	AST_CODING: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(state == APR_CONV && conv_cnt == 16'h0000) |=>
		(result[12:0] == $past(i_sample[12:0]) && result[13] == ($past(i_sample[13]) ^ BIPOLAR)))
		else $error("output coding wrong");

	// done stays low until an acquisition start releases it
	AST_DONE_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(!o_conv_done_n && !(fall && !host.read_conv)) |=> !o_conv_done_n)
		else $error("done released early");

endmodule

// ### rtl/apr_pkg.sv
// package for the converter power-mode and result readout block
// assumes a 50 MHz system clock; shared by the design and its bench
package apr_pkg;
	localparam int CLK_HZ = 50_000_000; // system clock rate
	localparam int CONV_TIME_NS = 4700; // longest conversion time, ns
	// longest time rounds down, never below one cycle
	localparam int CONV_CYCLES_RAW = (CONV_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
	localparam int RESULT_W = 14; // result width
	localparam int BYTE_W = 8; // bus width
	localparam int HI_BITS = RESULT_W - BYTE_W; // live bits in the high byte
	localparam logic [RESULT_W-1:0] MIDSCALE = 14'h2000; // offset binary flip
	localparam logic [1:0] PWR_OFF = 2'h0; // power-state codes
	localparam logic [1:0] PWR_STANDBY = 2'h1;
	localparam logic [1:0] PWR_ACTIVE = 2'h2;

	// sequencer states
	typedef enum logic [2:0] {
		APR_OFF,
		APR_STANDBY,
		APR_ACQ,
		APR_CONV,
		APR_DONE,
		APR_READ
	} apr_state_e;

	// host strobes as seen after synchronising
	typedef struct packed {
		logic conv_strobe_n; // active-low convert strobe
		logic read_conv; // read/convert select
		logic high_byte_select; // byte select
	} apr_host_s;
endpackage

// ### testbench/apr_host_model.sv
// host controller model that drives the strobe, select and byte-select pins
// assumes the bench calls its tasks; pins change only just after rising clock edges
`timescale 1ns/1ps
module apr_host_model
	import apr_pkg::*;
(
	input wire logic i_clk,
	input wire logic [BYTE_W-1:0] i_bus, // data pins as the device presents them
	input wire logic [BYTE_W-1:0] i_bus_oe, // device drive enables
	output logic o_conv_strobe_n, // convert strobe, active low
	output logic o_read_conv, // read/convert select
	output logic o_high_byte_select // byte select
);
	localparam int HOLD = 8; // strobe level hold, well above the two-clock minimum
	// an undriven bus reads as the host port pull-ups, never as the last value
	wire [BYTE_W-1:0] bus_seen;
	assign bus_seen = (i_bus & i_bus_oe) | ~i_bus_oe;

	// pins idle with the strobe high
	initial begin
		o_conv_strobe_n = 1'b1;
		o_read_conv = 1'b1;
		o_high_byte_select = 1'b0;
	end

	// one strobe pulse; select settles a clock before the fall and holds through it
	task automatic strobe_edge(input logic sel);
		@(posedge i_clk);
		o_read_conv <= sel;
		@(posedge i_clk);
		o_conv_strobe_n <= 1'b0;
		repeat (HOLD) @(posedge i_clk);
		o_conv_strobe_n <= 1'b1;
		repeat (HOLD) @(posedge i_clk);
	endtask

	// read strobe with select high, low byte first, then the high byte
	task automatic read_result(output logic [BYTE_W-1:0] lo, output logic [BYTE_W-1:0] hi,
			output logic [BYTE_W-1:0] en);
		@(posedge i_clk);
		o_read_conv <= 1'b1;
		o_high_byte_select <= 1'b0;
		@(posedge i_clk);
		o_conv_strobe_n <= 1'b0;
		// byte lags the select by several clocks, so wait twice the hold
		repeat (2 * HOLD) @(posedge i_clk);
		lo = bus_seen;
		en = i_bus_oe;
		o_high_byte_select <= 1'b1;
		repeat (2 * HOLD) @(posedge i_clk);
		hi = bus_seen;
		o_conv_strobe_n <= 1'b1;
		o_high_byte_select <= 1'b0;
		repeat (HOLD) @(posedge i_clk);
	endtask
endmodule

// ### testbench/apr_core_tb.sv
// self-checking bench for the converter strobe sequencer
// assumes apr_pkg, apr_core and the host model are compiled first
`timescale 1ns/1ps
module apr_core_tb
	import apr_pkg::*;
;
	logic clk = 1'b0; // 50 MHz system clock
	logic rst = 1'b1; // held for ten clocks at start
	logic [RESULT_W-1:0] smp = 14'h0000; // raw code from the analog side
	logic strobe_n, rc, hbs, done_n, track;
	logic [BYTE_W-1:0] bus, oe, lo, hi, en;
	logic [1:0] ref_pwr;
	int fails = 0;
	int compares = 0;
	int cycles = 0; // watchdog count, about 440 cycles needed
	localparam int WAKE_WAIT = 20; // reference settle wait, scaled down for simulation

	always #10 clk = ~clk;

	// short conversion keeps the run brief; the done checks rely on it ending within one strobe pulse
	apr_core #(.CONV_CYC(4), .BIPOLAR(1'b1)) i_dut (.i_clk(clk), .i_sys_rst(rst),
		.i_conv_strobe_n(strobe_n), .i_read_conv(rc), .i_high_byte_select(hbs), .i_sample(smp),
		.o_conv_done_n(done_n), .o_result_outputs(bus), .o_result_outputs_oe(oe),
		.o_ref_power(ref_pwr), .o_track(track));
	apr_host_model i_host (.i_clk(clk), .i_bus(bus), .i_bus_oe(oe), .o_conv_strobe_n(strobe_n),
		.o_read_conv(rc), .o_high_byte_select(hbs));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic conclude();
		if (fails == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fails++;
			conclude();
		end
	end

	task automatic test_reset();
		@(negedge clk);
		chk({done_n, track, ref_pwr}, 8'h08, "reset flags");
		chk(oe, 8'h00, "reset enables");
	endtask

	// first strobe with select high is not a start
	task automatic test_ignored_first();
		i_host.strobe_edge(1'b1);
		@(negedge clk);
		chk({track, ref_pwr}, 8'h00, "ignored start");
	endtask

	// one full cycle; mode picked by the second edge, checked after the read
	task automatic test_cycle(input logic [RESULT_W-1:0] code, input logic mode, input logic [1:0] pw);
		logic [RESULT_W-1:0] r;
		r = code ^ MIDSCALE; // offset binary: sign bit inverted
		repeat (WAKE_WAIT) @(posedge clk);
		smp <= code;
		i_host.strobe_edge(1'b0);
		@(negedge clk);
		chk({done_n, track, ref_pwr}, {6'h03, PWR_ACTIVE}, "acquire");
		chk(oe, 8'h00, "bus during acquire");
		i_host.strobe_edge(mode);
		@(negedge clk);
		chk({done_n, track}, 8'h00, "done after hold");
		chk(oe, 8'h00, "bus after conversion");
		i_host.read_result(lo, hi, en);
		chk(en, 8'hff, "bus driven");
		chk(lo, r[7:0], "low byte");
		chk(hi, {2'b00, r[13:8]}, "high byte");
		@(negedge clk);
		chk(oe, 8'h00, "bus released");
		chk({6'h00, ref_pwr}, {6'h00, pw}, "power mode");
	endtask

	// after done, an edge with select low restarts acquisition without a read
	task automatic test_restart();
		i_host.strobe_edge(1'b0);
		i_host.strobe_edge(1'b0);
		@(negedge clk);
		chk({7'h00, done_n}, 8'h00, "done before restart");
		i_host.strobe_edge(1'b0);
		@(negedge clk);
		chk({7'h00, track}, 8'h01, "restart acquires");
		chk({7'h00, done_n}, 8'h01, "done released");
		i_host.strobe_edge(1'b0);
		i_host.read_result(lo, hi, en);
		chk(en, 8'hff, "restart read");
		chk(lo, 8'h01, "restart low byte");
		chk(hi, 8'h20, "restart high byte");
	endtask

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		test_reset();
		test_ignored_first();
		test_cycle(14'h1234, 1'b0, PWR_STANDBY);
		test_cycle(14'h3fff, 1'b1, PWR_OFF);
		test_cycle(14'h0001, 1'b0, PWR_STANDBY);
		test_restart();
		conclude();
	end
endmodule
